// [pkg/fsg_consts.svh]
// Contract
// - Idle, sleep, stop modes always cut flash current.
// - Slow run cuts current when standby set, idle.
// - Standby writes fetched from flash are ignored.
// - Flash access during standby raises standby reset.
// - Interrupt with flash vectors clears standby first.
// - Interrupt with RAM vectors keeps standby unchanged.
// - RAM vector into flash during standby resets.
// - Serial programming holds port inputs fixed after reset.
// - Gated ports also gate shared peripheral inputs.
// - Clock enable bit ungates serial clock pin.
// - General enable bit ungates all other ports.
// - Normal mode ignores gate register, inputs enabled.
// - Standby register always reads all zeros.
// - Normal mode gate register reads zero, writes ignored.
`ifndef FSG_CONSTS_SVH
`define FSG_CONSTS_SVH
`define FSG_ADDR_W 5
`define FSG_OFS_POWERDOWN 5'h00
`define FSG_OFS_PORTGATE 5'h04
`define FSG_OFS_SYSCTL3 5'h08
`define FSG_OFS_STATE 5'h0C
`define FSG_OFS_IRQ_STATUS 5'h10
`define FSG_OFS_IRQ_ENABLE 5'h14
`define FSG_OFS_IRQ_CLEAR 5'h18
`define FSG_BIT_STANDBY 0
`define FSG_BIT_GENERAL_EN 0
`define FSG_BIT_SCLK_EN 1
`define FSG_BIT_VECTOR_SEL 0
`define FSG_PORTGATE_SERIAL_TOP 4'hF
`define FSG_STANDBY_RESET_VAL 1'h0
`define FSG_GATE_RESET_VAL 1'h0
`define FSG_VSEL_RESET_VAL 1'h0
`define FSG_EV_STANDBY_RESET 0
`define FSG_EV_AUTO_CLEAR 1
`define FSG_EV_WRITE_REFUSED 2
`define FSG_EV_W 3
`define FSG_UNMAPPED_READ 32'h0000_0000
`endif

// [pkg/fsg_pkg.sv]
package fsg_pkg;

  typedef enum logic [1:0]
  {
    FSG_IDLE = 2'h1,
    FSG_ACK = 2'h2
  } fsg_bus_state_t;

  typedef struct packed
  {
    fsg_bus_state_t busState;
    logic waitReq;
    logic [31:0] readData;
    logic standby;
    logic generalInEn;
    logic sclkInEn;
    logic vectorSel;
    logic [2:0] irqStatus;
    logic [2:0] irqEnable;
    logic irq;
    logic powerDown;
    logic standbyReset;
    logic portGeneralEn;
    logic portSclkEn;
  } fsg_state_t;

endpackage

// [verilog/fsg_flash_standby_gate.sv]
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`include "fsg_consts.svh"

module fsg_flash_standby_gate
#(
  parameter int DATA_W = 32
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`FSG_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [DATA_W-1:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [DATA_W-1:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic cpuFetchFromRam,
  input wire logic flashAccess,
  input wire logic interruptTaken,
  input wire logic ramVectorInFlash,
  input wire logic lowPowerMode,
  input wire logic slowSingleClockRun,
  input wire logic serialProgMode,
  output logic flashPowerDown,
  output logic flashStandbyReset,
  output logic generalInputEnable,
  output logic serialClockInputEnable,
  output logic peripheralInputEnable,
  output logic irq
);

  fsg_pkg::fsg_state_t s_reg;
  fsg_pkg::fsg_state_t s_next;

  logic request;
  logic accept;
  logic wrLow;
  logic [DATA_W-1:0] rdMux;
  logic [`FSG_EV_W-1:0] events;
  logic [`FSG_EV_W-1:0] clearMask;
  logic standbyAfterInt;
  logic wrPowerDown;
  logic wrPortGate;
  logic wrSysCtl;
  logic wrIrqEnable;
  logic wrIrqClear;
  logic [`FSG_EV_W-1:0] statusNext;

  assign request = avsRead | avsWrite;
  assign accept = (s_reg.busState == fsg_pkg::FSG_ACK);
  assign wrLow = accept & avsWrite & avsByteEnable[0];
  assign wrPowerDown = wrLow & (avsAddress == `FSG_OFS_POWERDOWN);
  assign wrPortGate = wrLow & (avsAddress == `FSG_OFS_PORTGATE);
  assign wrSysCtl = wrLow & (avsAddress == `FSG_OFS_SYSCTL3);
  assign wrIrqEnable = wrLow & (avsAddress == `FSG_OFS_IRQ_ENABLE);
  assign wrIrqClear = wrLow & (avsAddress == `FSG_OFS_IRQ_CLEAR);

  // Each status bit is sticky: its event sets it, a clear write with that bit
  // high drops it, and the event wins when both land in the same cycle so that
  // software can never lose a standby reset it has not yet seen.
  genvar gi;
  generate
    for (gi = 0; gi < `FSG_EV_W; gi++)
    begin : g_status
      always_comb
      begin
        if (events[gi])
        begin
          statusNext[gi] = 1'b1;
        end
        else if (clearMask[gi])
        begin
          statusNext[gi] = 1'b0;
        end
        else
        begin
          statusNext[gi] = s_reg.irqStatus[gi];
        end
      end
    end
  endgenerate

  // Read data is formed from the current state when the request is first seen.
  always_comb
  begin
    rdMux = `FSG_UNMAPPED_READ;
    unique case (avsAddress)
      `FSG_OFS_POWERDOWN:
      begin
        rdMux = '0;
      end
      `FSG_OFS_PORTGATE:
      begin
        if (serialProgMode)
        begin
          rdMux[7:4] = `FSG_PORTGATE_SERIAL_TOP;
          rdMux[`FSG_BIT_SCLK_EN] = s_reg.sclkInEn;
          rdMux[`FSG_BIT_GENERAL_EN] = s_reg.generalInEn;
        end
        else
        begin
          rdMux = '0;
        end
      end
      `FSG_OFS_SYSCTL3:
      begin
        rdMux[`FSG_BIT_VECTOR_SEL] = s_reg.vectorSel;
      end
      `FSG_OFS_STATE:
      begin
        rdMux[0] = s_reg.standby;
        rdMux[1] = s_reg.powerDown;
        rdMux[2] = s_reg.portGeneralEn;
        rdMux[3] = s_reg.portSclkEn;
      end
      `FSG_OFS_IRQ_STATUS:
      begin
        rdMux[`FSG_EV_W-1:0] = s_reg.irqStatus;
      end
      `FSG_OFS_IRQ_ENABLE:
      begin
        rdMux[`FSG_EV_W-1:0] = s_reg.irqEnable;
      end
      default:
      begin
        rdMux = `FSG_UNMAPPED_READ;
      end
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    events = '0;
    clearMask = '0;
    standbyAfterInt = s_reg.standby;

    unique case (s_reg.busState)
      fsg_pkg::FSG_IDLE:
      begin
        if (request)
        begin
          s_next.busState = fsg_pkg::FSG_ACK;
          s_next.waitReq = 1'b0;
          s_next.readData = avsRead ? rdMux : '0;
        end
      end
      fsg_pkg::FSG_ACK:
      begin
        s_next.busState = fsg_pkg::FSG_IDLE;
        s_next.waitReq = 1'b1;
      end
    endcase

    // Software writes to the standby bit. A write whose instruction came from
    // flash is dropped whole, so a stray store cannot cut the array under the
    // code that is running from it.
    if (wrPowerDown)
    begin
      if (cpuFetchFromRam)
      begin
        s_next.standby = avsWriteData[`FSG_BIT_STANDBY];
      end
      else
      begin
        s_next.standby = s_reg.standby;
        events[`FSG_EV_WRITE_REFUSED] = 1'b1;
      end
    end

    // An interrupt either clears standby before the flash vector fetch or
    // leaves it, and in the latter case a vector into flash still resets.
    if (interruptTaken)
    begin
      if (!s_reg.vectorSel)
      begin
        s_next.standby = 1'b0;
        standbyAfterInt = 1'b0;
        if (s_reg.standby)
        begin
          events[`FSG_EV_AUTO_CLEAR] = 1'b1;
        end
      end
      else
      begin
        s_next.standby = s_reg.standby;
        if (s_reg.standby && ramVectorInFlash)
        begin
          events[`FSG_EV_STANDBY_RESET] = 1'b1;
        end
      end
    end

    // An access in the same cycle as an auto-clearing interrupt sees the
    // cleared bit, since that access is the vector fetch itself.
    if (flashAccess && standbyAfterInt)
    begin
      events[`FSG_EV_STANDBY_RESET] = 1'b1;
    end
    s_next.standbyReset = events[`FSG_EV_STANDBY_RESET];

    // The reset clears standby so the array comes back powered.
    if (events[`FSG_EV_STANDBY_RESET])
    begin
      s_next.standby = `FSG_STANDBY_RESET_VAL;
    end

    // Low-power modes cut the current with no register setting. In slow run
    // the cut follows the standby bit, and an access this cycle lifts the cut
    // from the next edge only, since flashPowerDown is registered.
    if (lowPowerMode)
    begin
      s_next.powerDown = 1'b1;
    end
    else
    begin
      s_next.powerDown = slowSingleClockRun & s_next.standby & !flashAccess;
    end

    // The gate bits only exist in serial programming mode; in normal mode a
    // write is dropped and every input stays open.
    if (wrPortGate && serialProgMode)
    begin
      s_next.generalInEn = avsWriteData[`FSG_BIT_GENERAL_EN];
      s_next.sclkInEn = avsWriteData[`FSG_BIT_SCLK_EN];
    end

    if (serialProgMode)
    begin
      s_next.portGeneralEn = s_next.generalInEn;
      s_next.portSclkEn = s_next.sclkInEn;
    end
    else
    begin
      s_next.portGeneralEn = 1'b1;
      s_next.portSclkEn = 1'b1;
    end

    if (wrSysCtl)
    begin
      s_next.vectorSel = avsWriteData[`FSG_BIT_VECTOR_SEL];
    end

    if (wrIrqEnable)
    begin
      s_next.irqEnable = avsWriteData[`FSG_EV_W-1:0];
    end
    if (wrIrqClear)
    begin
      clearMask = avsWriteData[`FSG_EV_W-1:0];
    end
    s_next.irqStatus = statusNext;
    s_next.irq = |(s_next.irqStatus & s_next.irqEnable);
  end

  // Port enables come out of reset gated; in normal mode they open one edge
  // after release, before any peripheral can act on a pin.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_reg.busState <= fsg_pkg::FSG_IDLE;
      s_reg.waitReq <= 1'b1;
      s_reg.readData <= '0;
      s_reg.standby <= `FSG_STANDBY_RESET_VAL;
      s_reg.generalInEn <= `FSG_GATE_RESET_VAL;
      s_reg.sclkInEn <= `FSG_GATE_RESET_VAL;
      s_reg.vectorSel <= `FSG_VSEL_RESET_VAL;
      s_reg.irqStatus <= '0;
      s_reg.irqEnable <= '0;
      s_reg.irq <= 1'b0;
      s_reg.powerDown <= 1'b0;
      s_reg.standbyReset <= 1'b0;
      s_reg.portGeneralEn <= 1'b0;
      s_reg.portSclkEn <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign avsReadData = s_reg.readData;
  assign avsWaitRequest = s_reg.waitReq;
  assign flashPowerDown = s_reg.powerDown;
  assign flashStandbyReset = s_reg.standbyReset;
  assign generalInputEnable = s_reg.portGeneralEn;
  assign serialClockInputEnable = s_reg.portSclkEn;
  // Shared peripheral inputs follow the general port gate.
  assign peripheralInputEnable = s_reg.portGeneralEn;
  assign irq = s_reg.irq;

endmodule

// [verif/fsg_assertions.sv]
`include "fsg_consts.svh"

module fsg_assertions(
  input wire logic mclk,
  rst,
  avsWrite,
  avsWaitRequest,
  flashAccess,
  interruptTaken,
  lowPowerMode,
  slowSingleClockRun,
  serialProgMode,
  flashPowerDown,
  flashStandbyReset,
  generalInputEnable,
  serialClockInputEnable,
  peripheralInputEnable,
  input wire logic [4:0] avsAddress,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_gate_wr;
    avsWrite && !avsWaitRequest && avsAddress == `FSG_OFS_PORTGATE && avsByteEnable[0]
      && serialProgMode;
  endsequence
  a_idle_cut: assert property (lowPowerMode |=> flashPowerDown)
    else $error("No cut in low power.");
  a_run_no_cut: assert property (
    !lowPowerMode && !slowSingleClockRun |=> !flashPowerDown) else $error("Cut in run.");
  a_reset_cause: assert property (
    flashStandbyReset |-> $past(flashAccess || interruptTaken)) else $error("Stray reset.");
  a_serial_gated: assert property (
    $fell(rst) ##0 serialProgMode[*2] |-> !generalInputEnable && !serialClockInputEnable)
    else $error("Ports open after reset.");
  a_periph_gated: assert property (
    $past(serialProgMode) && !generalInputEnable |-> !peripheralInputEnable)
    else $error("Peripheral input open.");
  a_sclk_ungate: assert property (
    s_gate_wr ##0 avsWriteData[1] |-> ##[1:2] serialClockInputEnable)
    else $error("Clock pin gated.");
  a_gen_ungate: assert property (
    s_gate_wr ##0 avsWriteData[0] |-> ##[1:2] generalInputEnable)
    else $error("Ports gated.");
  a_normal_open: assert property (
    !serialProgMode ##1 !serialProgMode |-> generalInputEnable && serialClockInputEnable
      && peripheralInputEnable) else $error("Normal mode gated.");
endmodule

bind fsg_flash_standby_gate fsg_assertions fsg_assertions_i(.*);

// [verif/fsg_cpu_model.sv]
module fsg_cpu_model(
  input wire logic mclk,
  input wire logic [1:0] cmd,
  input wire logic fromRam,
  input wire logic vecFlash,
  output logic cpuFetchFromRam,
  output logic flashAccess,
  output logic interruptTaken,
  output logic ramVectorInFlash
);
  timeunit 1ns;
  timeprecision 100ps;
  // Standby writes come from the RAM routine only while the bench drives fromRam high.
  always_ff @(posedge mclk)
  begin
    cpuFetchFromRam <= fromRam;
    flashAccess <= cmd == 2'h1;
    interruptTaken <= cmd == 2'h2;
    ramVectorInFlash <= vecFlash;
  end
endmodule

// [verif/flash_standby_and_port_input_gate_test.sv]
`include "fsg_consts.svh"

module flash_standby_and_port_input_gate_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, avsRead, avsWrite, avsWaitRequest, lowPowerMode, slowSingleClockRun;
  logic serialProgMode, fromRam, vecFlash, cpuFetchFromRam, flashAccess, interruptTaken;
  logic ramVectorInFlash, flashPowerDown, flashStandbyReset, generalInputEnable;
  logic serialClockInputEnable, peripheralInputEnable, irq, sb, gen, sclk;
  logic [1:0] cmd;
  logic [4:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, q, rnd;
  int fails, totalChecks, resets, er;
  fsg_flash_standby_gate fsg_flash_standby_gate_i(.mclk, .rst, .avsAddress, .avsRead,
    .avsWrite, .avsWriteData, .avsByteEnable(4'hF), .avsReadData, .avsWaitRequest,
    .cpuFetchFromRam, .flashAccess, .interruptTaken, .ramVectorInFlash, .lowPowerMode,
    .slowSingleClockRun, .serialProgMode, .flashPowerDown, .flashStandbyReset,
    .generalInputEnable, .serialClockInputEnable, .peripheralInputEnable, .irq);
  fsg_cpu_model fsg_cpu_model_i(.mclk, .cmd, .fromRam, .vecFlash, .cpuFetchFromRam,
    .flashAccess, .interruptTaken, .ramVectorInFlash);
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (flashStandbyReset === 1'b1)
      resets++;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avsWaitRequest !== 1'b0 && n < 20);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      test_done();
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic cpu(input logic [1:0] k);
    @(posedge mclk);
    cmd <= k;
    @(posedge mclk);
    cmd <= 2'h0;
    repeat (3) @(posedge mclk);
  endtask
  function automatic logic [31:0] st4();
    st4 = {28'h0, sclk, gen, sb & slowSingleClockRun, sb};
  endfunction
  initial
  begin
    {rst, slowSingleClockRun, serialProgMode} = 3'h7;
    {avsRead, avsWrite, lowPowerMode, fromRam, vecFlash, sb, gen, sclk} = 8'h00;
    {cmd, avsAddress, avsWriteData} = 39'h0;
    {fails, totalChecks, resets, er} = 0;
    rnd = 32'd91687;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(`FSG_OFS_STATE, st4());
    rd(`FSG_OFS_PORTGATE, 32'hF0);
    chk({29'h0, peripheralInputEnable, serialClockInputEnable, generalInputEnable}, 0);
    bus(1'b1, `FSG_OFS_POWERDOWN, 32'h1);
    rd(`FSG_OFS_STATE, st4());
    fromRam <= 1'b1;
    bus(1'b1, `FSG_OFS_POWERDOWN, 32'h1);
    sb = 1'b1;
    rd(`FSG_OFS_POWERDOWN, 32'h0);
    rd(`FSG_OFS_STATE, st4());
    cpu(2'h1);
    er++;
    sb = 1'b0;
    chk(resets, er);
    rd(`FSG_OFS_STATE, st4());
    bus(1'b1, `FSG_OFS_POWERDOWN, 32'h1);
    bus(1'b1, `FSG_OFS_POWERDOWN, 32'h0);
    cpu(2'h1);
    chk(resets, er);
    bus(1'b1, `FSG_OFS_POWERDOWN, 32'h1);
    cpu(2'h2);
    chk(resets, er);
    rd(`FSG_OFS_STATE, st4());
    bus(1'b1, `FSG_OFS_SYSCTL3, 32'h1);
    bus(1'b1, `FSG_OFS_POWERDOWN, 32'h1);
    sb = 1'b1;
    cpu(2'h2);
    rd(`FSG_OFS_STATE, st4());
    vecFlash <= 1'b1;
    cpu(2'h2);
    er++;
    sb = 1'b0;
    chk(resets, er);
    rd(`FSG_OFS_IRQ_STATUS, 32'h7);
    bus(1'b1, `FSG_OFS_IRQ_ENABLE, 32'h1);
    rd(5'h1C, `FSG_UNMAPPED_READ);
    chk({31'h0, irq}, 1);
    bus(1'b1, `FSG_OFS_IRQ_CLEAR, 32'h7);
    rd(`FSG_OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 0);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      bus(1'b1, `FSG_OFS_PORTGATE, rnd);
      {sclk, gen} = rnd[1:0];
      rd(`FSG_OFS_STATE, st4());
      chk({29'h0, peripheralInputEnable, serialClockInputEnable, generalInputEnable},
        {29'h0, gen, sclk, gen});
    end
    serialProgMode <= 1'b0;
    bus(1'b1, `FSG_OFS_PORTGATE, 32'h0);
    rd(`FSG_OFS_PORTGATE, 32'h0);
    chk({29'h0, peripheralInputEnable, serialClockInputEnable, generalInputEnable}, 7);
    lowPowerMode <= 1'b1;
    slowSingleClockRun <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, flashPowerDown}, 1);
    lowPowerMode <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, flashPowerDown}, 0);
    test_done();
  end
endmodule
